// ---- rtl/wake_clk_pkg.sv ----
// Constants and types shared by the wake-up and clock-select logic
package wake_clk_pkg;

   // Power modes of the core
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_GREEN,
      MODE_IDLE,
      MODE_SLEEP
   } power_mode_type;

   // Wake sequencer states
   typedef enum logic [1:0] {
      ST_RUN,
      ST_LOW_POWER,
      ST_WAKE
   } wake_state_type;

   // Oscillator kinds
   typedef enum logic [1:0] {
      OSC_RC,
      OSC_CRYSTAL,
      OSC_LOOP,
      OSC_NONE
   } osc_kind_type;

   // Wake source bit positions
   localparam int SRC_TIMER_COUNTER = 0;
   localparam int SRC_EXT_PIN = 1;
   localparam int SRC_WATCH_TIMER = 2;
   localparam int SRC_TIMER1 = 3;
   localparam int SRC_TIMER2 = 4;
   localparam int SRC_ADC = 5;
   localparam int SRC_UART = 6;
   localparam int SRC_SPI = 7;
   localparam int SRC_LOW_VOLTAGE = 8;
   localparam int NUM_SRC = 9;

   // Sources allowed to end sleep and idle
   localparam logic [8:0] SLEEP_WAKE_MASK = 9'h022;
   localparam logic [8:0] IDLE_WAKE_MASK = 9'h1ff;

   // Wake-enable fields of the edge-select register
   localparam int EDGE_WAKE_LSB = 2;
   localparam int EDGE_WAKE_MSB = 4;

   // Multiplier field position and value
   localparam int MULT_FIELD_LSB = 4;
   localparam int MULT_FIELD_MSB = 6;
   localparam logic [8:0] LOOP_MULT = 9'h1e8;
   localparam logic [1:0] MULT_VALID_TOP = 2'h3;

   localparam logic [8:0] PENDING_RESET = 9'h000;

endpackage

// ---- rtl/wake_latch.sv ----
// Sticky holding register for wake requests
`timescale 1ns/100ps
module wake_latch
   import wake_clk_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request set and clear
   input wire logic [NUM_SRC-1:0] set_req,
   input wire logic clear,
   // Held state
   output logic [NUM_SRC-1:0] held
);

   typedef struct packed {
      logic [NUM_SRC-1:0] held;
   } latch_state_type;

   latch_state_type state_ff;
   latch_state_type nxt_state;

   // Set wins over clear so an event during clear survives
   always_comb
   begin
      nxt_state = state_ff;
      if (clear)
      begin
         nxt_state.held = '0;
      end
      nxt_state.held = nxt_state.held | set_req;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff.held <= PENDING_RESET;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   assign held = state_ff.held;

endmodule

// ---- rtl/wake_clock_ctrl.sv ----
// Wake-up qualification and clock source selection
//
// Notes on behaviour
// - The block ends both sleep and idle when a qualifying event arrives.
// - In sleep only the external pin and A/D complete events wake the core.
// - In idle every event wakes the core, the pin and A/D only with their wake enables, then interrupt if enabled.
// - After waking the core takes the interrupt when enabled, then resumes at the next step.
// - A watchdog timeout resets in every mode; in green and normal events only interrupt.
// - Two option bits pick main clock: 00 RC, 01 crystal, 1x loop, but 111 gives crystal.
// - Sub clock is RC when its select is 0, crystal when 1, none when all three bits are 1.
// - In loop mode the main clock comes from the sub oscillator.
// - Multiplier field bits 4 to 6: 11x gives sub clock times 488, others reserved.
`timescale 1ns/100ps
module wake_clock_ctrl
   import wake_clk_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Core power handshake
   input wire logic sleep_req,
   input wire logic idle_req,
   input wire logic green_mode,
   input wire logic global_int_en,
   // Event sources and enables
   input wire logic [NUM_SRC-1:0] event_pulse,
   input wire logic [NUM_SRC-1:0] int_enable,
   input wire logic watchdog_timeout,
   input wire logic [7:0] ext_edge_select_reg,
   input wire logic [7:0] wake_control_reg,
   // Code option bits
   input wire logic sub_clock_type_sel,
   input wire logic main_clock_type_sel_hi,
   input wire logic main_clock_type_sel_lo,
   input wire logic [7:0] clock_option_reg,
   // Status to the core
   output logic [1:0] power_mode,
   output logic core_halted,
   output logic wake_pulse,
   output logic int_take,
   output logic resume_next,
   output logic [NUM_SRC-1:0] int_request,
   output logic device_reset,
   // Clock selection
   output logic [1:0] main_osc_kind,
   output logic [1:0] sub_osc_kind,
   output logic main_from_sub,
   output logic [8:0] loop_multiplier,
   output logic mult_reserved
);

   // -----------------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------------
   function automatic logic [NUM_SRC-1:0] wake_gate(input power_mode_type m,
                                                    input logic [NUM_SRC-1:0] src,
                                                    input logic pin_en,
                                                    input logic adc_en);
      logic [NUM_SRC-1:0] g;
      g = '0;
      if (m == MODE_SLEEP)
      begin
         g = src & SLEEP_WAKE_MASK;
      end
      else if (m == MODE_IDLE)
      begin
         g = src & IDLE_WAKE_MASK;
      end
      // Pin and A/D wake need their enables
      g[SRC_EXT_PIN] = g[SRC_EXT_PIN] & pin_en;
      g[SRC_ADC] = g[SRC_ADC] & adc_en;
      return g;
   endfunction

   typedef struct packed {
      wake_state_type state;
      power_mode_type mode;
      logic halted;
      logic wake;
      logic take;
      logic resume;
      logic [NUM_SRC-1:0] intr;
      logic wdt_rst;
      osc_kind_type main_kind;
      osc_kind_type sub_kind;
      logic from_sub;
      logic [8:0] mult;
      logic mult_rsv;
   } ctrl_state_type;

   ctrl_state_type state_ff;
   ctrl_state_type nxt_state;
   logic [NUM_SRC-1:0] held;
   logic [NUM_SRC-1:0] latch_set;
   logic latch_clear;
   logic pin_wake_en;
   logic adc_wake_en;
   logic [NUM_SRC-1:0] qualifying;
   logic [2:0] mult_field;

   // -----------------------------------------------------------------
   // Wake request holding
   // -----------------------------------------------------------------
   assign pin_wake_en = |ext_edge_select_reg[EDGE_WAKE_MSB:EDGE_WAKE_LSB];
   assign adc_wake_en = &wake_control_reg;
   assign latch_set = event_pulse;
   // Served requests drop at wake so they cannot end the next sleep at once
   assign latch_clear = (state_ff.state == ST_WAKE)
                        || ((state_ff.state == ST_RUN) && !sleep_req && !idle_req);

   // Events arriving while entering low power are kept
   wake_latch u_latch (
      .clk(clk),
      .reset_n(reset_n),
      .set_req(latch_set),
      .clear(latch_clear),
      .held(held)
   );

   assign qualifying = wake_gate(state_ff.mode, held | event_pulse,
                                 pin_wake_en, adc_wake_en);
   assign mult_field = clock_option_reg[MULT_FIELD_MSB:MULT_FIELD_LSB];

   // -----------------------------------------------------------------
   // Next state
   // -----------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_state.wake = 1'b0;
      nxt_state.take = 1'b0;
      nxt_state.resume = 1'b0;
      nxt_state.wdt_rst = watchdog_timeout;
      nxt_state.intr = '0;
      case (state_ff.state)
         ST_RUN:
         begin
            nxt_state.halted = 1'b0;
            nxt_state.mode = green_mode ? MODE_GREEN : MODE_NORMAL;
            // Running: events only raise interrupts
            nxt_state.intr = event_pulse & int_enable;
            if (sleep_req)
            begin
               nxt_state.state = ST_LOW_POWER;
               nxt_state.mode = MODE_SLEEP;
               nxt_state.halted = 1'b1;
            end
            else if (idle_req)
            begin
               nxt_state.state = ST_LOW_POWER;
               nxt_state.mode = MODE_IDLE;
               nxt_state.halted = 1'b1;
            end
         end
         ST_LOW_POWER:
         begin
            if (|qualifying)
            begin
               nxt_state.state = ST_WAKE;
               nxt_state.halted = 1'b0;
               nxt_state.wake = 1'b1;
            end
         end
         ST_WAKE:
         begin
            // Interrupt then resume, or plain resume
            nxt_state.intr = held & int_enable;
            nxt_state.take = global_int_en && |(held & int_enable);
            nxt_state.resume = 1'b1;
            nxt_state.state = ST_RUN;
            nxt_state.mode = green_mode ? MODE_GREEN : MODE_NORMAL;
         end
         default:
         begin
            nxt_state.state = ST_RUN;
         end
      endcase
      if (watchdog_timeout)
      begin
         nxt_state.state = ST_RUN;
         nxt_state.mode = MODE_NORMAL;
         nxt_state.halted = 1'b0;
      end

      // Clock source decode
      if (sub_clock_type_sel && main_clock_type_sel_hi && main_clock_type_sel_lo)
      begin
         nxt_state.main_kind = OSC_CRYSTAL;
         nxt_state.sub_kind = OSC_NONE;
      end
      else
      begin
         if (main_clock_type_sel_hi)
         begin
            nxt_state.main_kind = OSC_LOOP;
         end
         else if (main_clock_type_sel_lo)
         begin
            nxt_state.main_kind = OSC_CRYSTAL;
         end
         else
         begin
            nxt_state.main_kind = OSC_RC;
         end
         nxt_state.sub_kind = sub_clock_type_sel ? OSC_CRYSTAL : OSC_RC;
      end
      nxt_state.from_sub = (nxt_state.main_kind == OSC_LOOP);
      // Reserved patterns leave the multiplier at zero
      nxt_state.mult_rsv = (mult_field[2:1] != MULT_VALID_TOP);
      nxt_state.mult = nxt_state.mult_rsv ? 9'h000 : LOOP_MULT;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
      end
   end

   // -----------------------------------------------------------------
   // Outputs
   // -----------------------------------------------------------------
   assign power_mode = state_ff.mode;
   assign core_halted = state_ff.halted;
   assign wake_pulse = state_ff.wake;
   assign int_take = state_ff.take;
   assign resume_next = state_ff.resume;
   assign int_request = state_ff.intr;
   assign device_reset = state_ff.wdt_rst;
   assign main_osc_kind = state_ff.main_kind;
   assign sub_osc_kind = state_ff.sub_kind;
   assign main_from_sub = state_ff.from_sub;
   assign loop_multiplier = state_ff.mult;
   assign mult_reserved = state_ff.mult_rsv;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_sleep_timer_blocked: assert property (@(posedge clk) disable iff (!reset_n)
      (state_ff.state == ST_LOW_POWER && state_ff.mode == MODE_SLEEP
       && (held | event_pulse) == (9'h001 << SRC_TIMER1) && !watchdog_timeout)
      |=> !wake_pulse)
      else $error("timer woke the core from sleep");

   a_idle_any_wakes: assert property (@(posedge clk) disable iff (!reset_n)
      (state_ff.state == ST_LOW_POWER && state_ff.mode == MODE_IDLE
       && event_pulse[SRC_UART] && !watchdog_timeout) |=> wake_pulse)
      else $error("idle did not wake on uart");

   a_wake_then_resume: assert property (@(posedge clk) disable iff (!reset_n)
      wake_pulse && !$past(watchdog_timeout) && !watchdog_timeout |=> resume_next)
      else $error("no resume after wake");

   a_wdt_resets: assert property (@(posedge clk) disable iff (!reset_n)
      watchdog_timeout |=> device_reset && !core_halted)
      else $error("watchdog did not reset");

   a_pin_needs_enable: assert property (@(posedge clk) disable iff (!reset_n)
      (state_ff.state == ST_LOW_POWER && pin_wake_en == 1'b0 && adc_wake_en == 1'b0
       && state_ff.mode == MODE_SLEEP && !watchdog_timeout) |=> !wake_pulse)
      else $error("sleep wake without enable");

   a_main_clock_sel: assert property (@(posedge clk) disable iff (!reset_n)
      (main_clock_type_sel_hi && !sub_clock_type_sel)
      |=> main_osc_kind == OSC_LOOP && main_from_sub)
      else $error("loop main clock not chosen");

   a_sub_clock_none: assert property (@(posedge clk) disable iff (!reset_n)
      (sub_clock_type_sel && main_clock_type_sel_hi && main_clock_type_sel_lo)
      |=> sub_osc_kind == OSC_NONE && main_osc_kind == OSC_CRYSTAL)
      else $error("all-ones option decoded wrong");

   a_mult_value: assert property (@(posedge clk) disable iff (!reset_n)
      (mult_field[2:1] == 2'h3) |=> loop_multiplier == 9'h1e8 && !mult_reserved)
      else $error("multiplier not 488");

   a_event_held: assert property (@(posedge clk) disable iff (!reset_n)
      (state_ff.state == ST_LOW_POWER && event_pulse[SRC_EXT_PIN]) |=> held[SRC_EXT_PIN])
      else $error("wake request lost");

endmodule

// ---- sim/event_source.sv ----
// Peripheral and pin event model feeding the wake-up block
`timescale 1ns/100ps
module event_source
   import wake_clk_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Request from the bench
   input wire logic fire,
   input wire logic [3:0] src,
   // Events to the block
   output logic [NUM_SRC-1:0] event_pulse
);
   // ---------------------------------------------
   // One-cycle event per request
   // ---------------------------------------------
   // Registered so events always land one edge after the request
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         event_pulse <= 9'h000;
      else
         event_pulse <= fire ? (9'h001 << src) : 9'h000;
   end
endmodule

// ---- sim/wakeup_and_clock_source_select_tb_top.sv ----
// Self-checking bench for the wake-up and clock-select block
`timescale 1ns/100ps
module wakeup_and_clock_source_select_tb_top
   import wake_clk_pkg::*;
;
   logic clk, reset_n, sleep_req, idle_req, green_mode, global_int_en, watchdog_timeout, fire;
   logic sub_clock_type_sel, main_clock_type_sel_hi, main_clock_type_sel_lo;
   logic [3:0] src;
   logic [NUM_SRC-1:0] event_pulse, int_enable, int_request, held;
   logic [7:0] ext_edge_select_reg, wake_control_reg, clock_option_reg;
   logic [1:0] power_mode, main_osc_kind, sub_osc_kind;
   logic core_halted, wake_pulse, int_take, resume_next, device_reset, main_from_sub;
   logic mult_reserved, hit;
   logic [8:0] loop_multiplier;
   int num_errors, n_checks, expm;

   wake_clock_ctrl dut (.clk, .reset_n, .sleep_req, .idle_req, .green_mode, .global_int_en,
      .event_pulse, .int_enable, .watchdog_timeout, .ext_edge_select_reg, .wake_control_reg,
      .sub_clock_type_sel, .main_clock_type_sel_hi, .main_clock_type_sel_lo,
      .clock_option_reg, .power_mode, .core_halted, .wake_pulse, .int_take, .resume_next,
      .int_request, .device_reset, .main_osc_kind, .sub_osc_kind, .main_from_sub,
      .loop_multiplier, .mult_reserved);
   event_source peers (.clk, .reset_n, .fire, .src, .event_pulse);

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic pulse(input int s);
      fire <= 1'b1;
      src <= 4'(s);
      @(posedge clk);
      fire <= 1'b0;
   endtask

   // Bounded wait, so a missing wake never hangs the run
   task automatic wait_wake();
      hit = 1'b0;
      for (int k = 0; k < 5 && !hit; k++)
      begin
         @(posedge clk);
         #1;
         hit = (wake_pulse === 1'b1);
      end
   endtask

   // Enter sleep or idle, fire one source, resume by the pin if still halted
   task automatic low_power(input bit sl, input int s);
      @(posedge clk);
      int_enable <= 9'($urandom);
      global_int_en <= 1'($urandom);
      ext_edge_select_reg <= 8'h04 << ($urandom % 3);
      wake_control_reg <= 8'hff;
      sleep_req <= sl;
      idle_req <= !sl;
      @(posedge clk);
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
      @(posedge clk);
      #1;
      chk(power_mode, sl ? 9'h003 : 9'h002);
      @(posedge clk);
      held = 9'h001 << s;
      pulse(s);
      wait_wake();
      chk(hit, !sl || s == SRC_EXT_PIN || s == SRC_ADC);
      if (!hit)
      begin
         @(posedge clk);
         held = held | 9'h002;
         pulse(SRC_EXT_PIN);
         wait_wake();
         chk(hit, 1'b1);
      end
      @(posedge clk);
      #1;
      chk(resume_next, 1'b1);
      chk(int_request, held & int_enable);
      chk(int_take, global_int_en && |(held & int_enable));
      chk(core_halted, 1'b0);
   endtask

   // ---------------------------------------------
   // Clock, watchdog and main sequence
   // ---------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   initial
   begin
      #20000;
      num_errors++;
      stop_test();
   end

   initial
   begin
      {reset_n, sleep_req, idle_req, green_mode, global_int_en, watchdog_timeout, fire} = '0;
      {sub_clock_type_sel, main_clock_type_sel_hi, main_clock_type_sel_lo} = '0;
      {src, int_enable, ext_edge_select_reg, wake_control_reg, clock_option_reg} = '0;
      void'($urandom(48175));
      repeat (16) @(posedge clk);
      chk(core_halted, 1'b0);
      chk(power_mode, 9'h000);
      reset_n <= 1'b1;
      $display("test reset done");
      for (int m = 0; m < 8; m++)
      begin
         @(posedge clk);
         {sub_clock_type_sel, main_clock_type_sel_hi, main_clock_type_sel_lo} <= 3'(m);
         clock_option_reg <= 8'($urandom) | (m[0] ? 8'h60 : 8'h00);
         repeat (2) @(posedge clk);
         #1;
         expm = (m == 7) ? 1 : ((m & 2) != 0) ? 2 : (m & 1);
         chk(main_osc_kind, 9'(expm));
         chk(sub_osc_kind, (m == 7) ? 9'h003 : 9'(m >> 2));
         chk(main_from_sub, expm == 2);
         chk(loop_multiplier, clock_option_reg[6:5] == 2'h3 ? 9'h1e8 : 9'h000);
         chk(mult_reserved, clock_option_reg[6:5] != 2'h3);
      end
      $display("test clock select done");
      for (int s = 0; s < NUM_SRC; s++)
      begin
         low_power(1'b1, s);
         low_power(1'b0, s);
      end
      $display("test wake sources done");
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clk);
         ext_edge_select_reg <= 8'($urandom) & 8'he3;
         wake_control_reg <= 8'($urandom) & 8'hfe;
         sleep_req <= (i == 0);
         idle_req <= (i == 1);
         @(posedge clk);
         sleep_req <= 1'b0;
         idle_req <= 1'b0;
         pulse(SRC_EXT_PIN);
         @(posedge clk);
         pulse(SRC_ADC);
         wait_wake();
         chk(hit, 1'b0);
         @(posedge clk);
         ext_edge_select_reg <= 8'h08;
         wait_wake();
         chk(hit, 1'b1);
         @(posedge clk);
         #1;
         chk(resume_next, 1'b1);
         chk(int_request, 9'h022 & int_enable);
         chk(int_take, global_int_en && |(9'h022 & int_enable));
      end
      $display("test wake enables done");
      for (int g = 0; g < 2; g++)
      begin
         for (int s = 0; s < NUM_SRC; s++)
         begin
            @(posedge clk);
            green_mode <= g[0];
            int_enable <= 9'($urandom);
            pulse(s);
            @(posedge clk);
            #1;
            chk(int_request, (9'h001 << s) & int_enable);
            chk(wake_pulse | core_halted, 1'b0);
            chk(power_mode, 9'(g));
         end
      end
      $display("test run modes done");
      // Watchdog in normal, green, idle and sleep
      for (int md = 0; md < 4; md++)
      begin
         @(posedge clk);
         green_mode <= (md == 1);
         idle_req <= (md == 2);
         sleep_req <= (md == 3);
         @(posedge clk);
         sleep_req <= 1'b0;
         idle_req <= 1'b0;
         watchdog_timeout <= 1'b1;
         @(posedge clk);
         watchdog_timeout <= 1'b0;
         #1;
         chk(device_reset, 1'b1);
         chk(core_halted, 1'b0);
         chk(power_mode, 9'h000);
         @(posedge clk);
         #1;
         chk(device_reset, 1'b0);
      end
      $display("test watchdog done");
      stop_test();
   end
endmodule
